// *** dv/field_model.sv ***
`timescale 1ns/1ps
module field_model
    import trip_release_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Requested field state.
    input wire pins_s want,
    input wire logic [NB-1:0] relay_trip,
    input wire logic slow,
    // Pins towards the block.
    output pins_s field_in
);
    pins_s lag_r;
    logic [NB-1:0] junk_r;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lag_r <= '0;
            junk_r <= '0;
        end else begin
            lag_r <= want;
            junk_r <= ~junk_r;
        end
    end
    always_comb begin
        field_in = slow ? lag_r : want;
        field_in.bay_volt_release = (want.bay_volt_release & want.bay_volt_valid) | (junk_r & ~want.bay_volt_valid);
        field_in.bay_trip_req = field_in.bay_trip_req | relay_trip;
        field_in.failure_start = field_in.failure_start | relay_trip;
    end
endmodule : field_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import trip_release_pkg::*;
;
    localparam int TICK = 4;
    logic core_clk = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slow = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF, relay_trip = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [NZ-1:0] zone_trip, failure_local_intertrip;
    logic [NB-1:0] bay_trip, failure_retrip, failure_remote_transfer_trip;
    pins_s want = '0, field_in, p;
    int mismatches = 0, total_checks = 0, seed = 42247;
    logic [95:0] r96;
    logic [2:0] c;
    logic [NZ-1:0] ez;
    logic [NB-1:0] eb;
    logic [4:0] row [6] = '{5'h04, 5'h00, 5'h14, 5'h14, 5'h08, 5'h08};
    logic [5:0] cur [6] = '{6'h08, 6'h08, 6'h07, 6'h08, 6'h06, 6'h07};
    logic [1:0] res [6] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h0, 2'h2};
    logic [7:0] rst_ofs [5] = '{CTRL_OFS, CRIT_OFS, PICKUP_OFS, DELAY1_OFS, DELAY2_OFS};
    logic [31:0] rst_val [5] = '{32'h0, 32'h0, 32'h7, 32'h64, 32'hC8};
    field_model i_field_model (.core_clk(core_clk), .rst(rst), .want(want), .relay_trip(relay_trip),
        .slow(slow), .field_in(field_in));
    trip_release_redirection #(.TICK_COUNT(TICK)) i_trip_release_redirection (.core_clk(core_clk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .field_in(field_in), .zone_trip(zone_trip),
        .bay_trip(bay_trip), .failure_retrip(failure_retrip), .failure_local_intertrip(failure_local_intertrip),
        .failure_remote_transfer_trip(failure_remote_transfer_trip));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task automatic conclude();
        if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (!s_axi_bvalid);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read
    // A criterion is kept only when its sources are configured; bay release needs one.
    function automatic logic [31:0] exp_crit(input logic [1:0] cfg, input logic [3:0] w);
        logic ok;
        ok = (w[2:0] == 3'h1 && cfg[0]) || (w[2:0] == 3'h2 && cfg[1]) || (w[2:0] inside {3'h3, 3'h4} && cfg == 2'h3);
        return ok ? 32'(w) : 32'h0;
    endfunction : exp_crit
    function automatic logic [NZ-1:0] exp_zone(input pins_s q, input logic [2:0] k);
        logic [NZ-1:0] v, e;
        v = '1;
        for (int z = 0; z < NZ; z++) for (int b = 0; b < NB; b++)
            if (q.bay_zone_map[b*NZ+z] && q.bay_volt_valid[b] && !q.bay_volt_release[b]) v[z] = 1'b0;
        e = q.zone_external_release;
        for (int z = 1; z < NZ; z++) if (q.zone_join[z-1]) e[z] = e[z] & e[z-1];
        for (int z = NZ - 2; z >= 0; z--) if (q.zone_join[z]) e[z] = e[z] & e[z+1];
        case (k)
            3'h1: return q.zone_trip_req & v;
            3'h2: return q.zone_trip_req & e;
            3'h3: return q.zone_trip_req & v & e;
            3'h4: return q.zone_trip_req & (v | e);
            default: return q.zone_trip_req;
        endcase
    endfunction : exp_zone
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            axi_read(rst_ofs[i], rd, rr);
            chk(rd, rst_val[i]);
        end
        axi_read(8'h1C, rd, rr);
        chk(rd, 32'h0);
        chk(32'(rr), 32'(RESP_SLVERR));
        axi_write(8'h1C, 32'h1);
        chk(32'(br), 32'(RESP_SLVERR));
        for (int g = 0; g < 4; g++) for (int k = 0; k < 5; k++) begin
            axi_write(CTRL_OFS, 32'(g));
            axi_write(CRIT_OFS, {28'h0, 1'b1, 3'(k)});
            axi_read(CRIT_OFS, rd, rr);
            chk(rd, exp_crit(2'(g), {1'b1, 3'(k)}));
        end
        for (int i = 0; i < 40; i++) begin
            c = 3'(($random(seed) & 32'h7FFF) % 5);
            axi_write(CRIT_OFS, {29'h0, c});
            r96 = {$random(seed), $random(seed), $random(seed)};
            p = pins_s'(r96[71:0]);
            p.bay_trip_req = '0;
            p.failure_start = '0;
            p.trip_redirect_req = '0;
            if (c != 3'h2) p.zone_join = '0;
            want <= p;
            slow <= r96[72];
            repeat (6) @(posedge core_clk);
            ez = exp_zone(p, c);
            chk(32'(zone_trip), 32'(ez));
            for (int b = 0; b < NB; b++) eb[b] = |(p.bay_zone_map[b*NZ +: NZ] & ez);
            chk(32'(bay_trip), 32'(eb));
        end
        axi_write(CRIT_OFS, 32'h0);
        for (int i = 0; i < 6; i++) begin
            axi_write(CTRL_OFS, 32'(row[i]));
            p = '0;
            p.bay_zone_map[1] = 1'b1;
            p.trip_redirect_req[0] = (i < 4);
            p.bay_current[5:0] = cur[i];
            want <= p;
            relay_trip <= 4'h1;
            repeat (8) @(posedge core_clk);
            chk({bay_trip[0], failure_remote_transfer_trip[0], failure_local_intertrip}, {res[i], 2'h0, res[i][0], 1'b0});
            relay_trip <= 4'h0;
            repeat (6) @(posedge core_clk);
        end
        axi_write(CTRL_OFS, 32'h4);
        axi_write(DELAY1_OFS, 32'h14);
        for (int t = 0; t < 2; t++) begin
            p = '0;
            p.failure_start[1] = 1'b1;
            p.trip_transferred = t[0];
            want <= p;
            repeat (MIN_DELAY_MS * TICK + 12) @(posedge core_clk);
            chk(32'(failure_retrip[1]), 32'(t));
            want <= '0;
            repeat (6) @(posedge core_clk);
        end
        conclude();
    end
endmodule : tb_top

// *** dv/trip_release_redirection_sva.sv ***
`timescale 1ns/1ps
module trip_release_sva
    import trip_release_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Register bus.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Field side.
    input wire pins_s field_in,
    input wire logic [NZ-1:0] zone_trip,
    input wire logic [NB-1:0] failure_retrip,
    input wire logic [NB-1:0] failure_remote_transfer_trip
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_reset_idle;
        disable iff (1'b0) rst ##1 rst |-> !s_axi_bvalid && !s_axi_rvalid && s_axi_arready && zone_trip == '0;
    endproperty
    property p_wr_answer;
        s_wr_both |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_b_refuse;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_rd_answer;
        s_rd_take |=> s_axi_rvalid;
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_r_refuse;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    // Outputs trail the pins by two synchroniser stages and the output flop.
    property p_zone_cause;
        (zone_trip & ~$past(field_in.zone_trip_req, 3)) == '0;
    endproperty
    property p_retrip_cause;
        (failure_retrip & ~$past(field_in.failure_start, 3)) == '0;
    endproperty
    property p_remote_cause;
        (failure_remote_transfer_trip & ~$past(field_in.failure_start | field_in.trip_redirect_req, 3)) == '0;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle in reset");
    a_wr_answer: assert property (p_wr_answer) else $error("write response late");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_b_refuse: assert property (p_b_refuse) else $error("write taken while response pending");
    a_rd_answer: assert property (p_rd_answer) else $error("read response late");
    a_r_hold: assert property (p_r_hold) else $error("read response dropped");
    a_r_refuse: assert property (p_r_refuse) else $error("read taken while response pending");
    a_zone_cause: assert property (p_zone_cause) else $error("zone trip without request");
    a_retrip_cause: assert property (p_retrip_cause) else $error("retrip without start");
    a_remote_cause: assert property (p_remote_cause) else $error("remote trip without cause");
endmodule : trip_release_sva
bind trip_release_redirection trip_release_sva i_trip_release_sva (.core_clk(core_clk), .rst(rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .field_in(field_in), .zone_trip(zone_trip), .failure_retrip(failure_retrip),
    .failure_remote_transfer_trip(failure_remote_transfer_trip));

// *** rtl/trip_release_pkg.sv ***
package trip_release_pkg;
    localparam int NZ = 4;
    localparam int NB = 4;
    localparam int CUR_W = 6;
    localparam int MS_W = 16;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CRIT_OFS = 8'h04;
    localparam logic [7:0] PICKUP_OFS = 8'h08;
    localparam logic [7:0] DELAY1_OFS = 8'h0C;
    localparam logic [7:0] DELAY2_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    localparam logic [7:0] INPUTS_OFS = 8'h18;

    // Control register fields.
    localparam int CTRL_VOLT_CFG = 0;
    localparam int CTRL_EXT_CFG = 1;
    localparam int CTRL_BFP_REL = 2;
    localparam int CTRL_OC_ACT = 3;
    localparam int CTRL_REDIR_LC = 4;
    localparam int CTRL_W = 5;
    localparam int CRIT_BAY_BIT = 3;

    // Reset values and limits; pick-up is in tenths of nominal current.
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [CUR_W-1:0] PICKUP_RST = 6'h07;
    localparam logic [CUR_W-1:0] PICKUP_MIN = 6'h01;
    localparam logic [CUR_W-1:0] PICKUP_MAX = 6'h28;
    localparam int MIN_DELAY_MS = 10;
    localparam logic [MS_W-1:0] MIN_DELAY = MS_W'(MIN_DELAY_MS);
    localparam logic [MS_W-1:0] DELAY1_RST = 16'h0064;
    localparam logic [MS_W-1:0] DELAY2_RST = 16'h00C8;

    // Processing tick period.
    localparam int TICK_NS = 1000000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        CRIT_NONE = 3'h0,
        CRIT_VOLT = 3'h1,
        CRIT_EXT = 3'h2,
        CRIT_AND = 3'h3,
        CRIT_OR = 3'h4
    } crit_e;

    typedef struct packed {
        logic [NZ-1:0] zone_external_release;
        logic [NZ-1:0] zone_trip_req;
        logic [NZ-2:0] zone_join;
        logic [NB-1:0] bay_volt_release;
        logic [NB-1:0] bay_volt_valid;
        logic [NB-1:0] bay_trip_req;
        logic [NB-1:0] failure_start;
        logic [NB-1:0] trip_redirect_req;
        logic trip_transferred;
        logic [NB*NZ-1:0] bay_zone_map;
        logic [NB*CUR_W-1:0] bay_current;
    } pins_s;
endpackage : trip_release_pkg

// *** rtl/trip_release_redirection.sv ***
`timescale 1ns/1ps
module trip_release_redirection
    import trip_release_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Field inputs, asynchronous to core_clk.
    input wire pins_s field_in,
    // Trip outputs.
    output logic [NZ-1:0] zone_trip,
    output logic [NB-1:0] bay_trip,
    output logic [NB-1:0] failure_retrip,
    output logic [NZ-1:0] failure_local_intertrip,
    output logic [NB-1:0] failure_remote_transfer_trip
);
    pins_s meta_r, pin_r;
    logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
    crit_e crit_r, crit_nxt;
    logic bay_rel_r, bay_rel_nxt;
    logic [CUR_W-1:0] pickup_r, pickup_nxt;
    logic [MS_W-1:0] delay1_r, delay1_nxt, delay2_r, delay2_nxt;
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic [7:0] aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [31:0] tick_r, tick_nxt;
    logic [MS_W-1:0] bf_cnt_r [NB];
    logic [MS_W-1:0] bf_cnt_nxt [NB];
    logic [NZ-1:0] zone_trip_nxt, local_int_nxt;
    logic [NB-1:0] bay_trip_nxt, retrip_nxt, remote_nxt;
    crit_e crit_eff;
    logic [NZ-1:0] zone_volt_ok, zone_ext_ok, zone_rel, ext_fwd, ext_bwd;
    logic [NB-1:0] bay_volt_ok, bay_ext_ok, bay_ok, cur_ok, cur_hi, redir_act, redir_fire;
    logic [NB-1:0] bf_intertrip, zone_hit, zone_req_hit;
    logic [MS_W-1:0] d1_eff, d2_eff;
    logic tick;

    function automatic logic gate_open(crit_e c, logic v, logic e);
        case (c)
            CRIT_VOLT: gate_open = v;
            CRIT_EXT: gate_open = e;
            CRIT_AND: gate_open = v & e;
            CRIT_OR: gate_open = v | e;
            default: gate_open = 1'b1;
        endcase
    endfunction : gate_open

    function automatic logic crit_legal(crit_e c, logic [CTRL_W-1:0] ctl);
        case (c)
            CRIT_NONE: crit_legal = 1'b1;
            CRIT_VOLT: crit_legal = ctl[CTRL_VOLT_CFG];
            CRIT_EXT: crit_legal = ctl[CTRL_EXT_CFG];
            CRIT_AND, CRIT_OR: crit_legal = ctl[CTRL_VOLT_CFG] & ctl[CTRL_EXT_CFG];
            default: crit_legal = 1'b0;
        endcase
    endfunction : crit_legal

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            pin_r <= '0;
        end else begin
            meta_r <= field_in;
            pin_r <= meta_r;
        end
    end

    // Protection evaluation.
    always_comb begin
        crit_eff = crit_legal(crit_r, ctrl_r) ? crit_r : CRIT_NONE;
        tick = (tick_r == TICK_COUNT - 1);
        tick_nxt = tick ? 32'h0 : tick_r + 32'h1;
        d1_eff = (pin_r.trip_transferred && ctrl_r[CTRL_BFP_REL]) ? MIN_DELAY
            : ((delay1_r < MIN_DELAY) ? MIN_DELAY : delay1_r);
        d2_eff = (pin_r.trip_transferred && ctrl_r[CTRL_BFP_REL]) ? MIN_DELAY
            : ((delay2_r < MIN_DELAY) ? MIN_DELAY : delay2_r);
        for (int b = 0; b < NB; b++) begin
            bay_volt_ok[b] = pin_r.bay_volt_release[b] | ~pin_r.bay_volt_valid[b];
            cur_hi[b] = pin_r.bay_current[b*CUR_W +: CUR_W] > pickup_r;
            cur_ok[b] = ~ctrl_r[CTRL_OC_ACT] | (pin_r.bay_current[b*CUR_W +: CUR_W] >= pickup_r);
        end
        for (int z = 0; z < NZ; z++) begin
            zone_volt_ok[z] = 1'b1;
            for (int b = 0; b < NB; b++) begin
                if (pin_r.bay_zone_map[b*NZ+z] && !bay_volt_ok[b]) begin
                    zone_volt_ok[z] = 1'b0;
                end
            end
        end
        ext_fwd[0] = pin_r.zone_external_release[0];
        for (int z = 1; z < NZ; z++) begin
            ext_fwd[z] = pin_r.zone_external_release[z] & (~pin_r.zone_join[z-1] | ext_fwd[z-1]);
        end
        ext_bwd[NZ-1] = pin_r.zone_external_release[NZ-1];
        for (int z = NZ - 2; z >= 0; z--) begin
            ext_bwd[z] = pin_r.zone_external_release[z] & (~pin_r.zone_join[z] | ext_bwd[z+1]);
        end
        for (int z = 0; z < NZ; z++) begin
            zone_ext_ok[z] = ext_fwd[z] & ext_bwd[z];
            zone_rel[z] = gate_open(crit_eff, zone_volt_ok[z], zone_ext_ok[z]);
            zone_trip_nxt[z] = pin_r.zone_trip_req[z] & zone_rel[z];
        end
        for (int b = 0; b < NB; b++) begin
            bay_ext_ok[b] = 1'b1;
            zone_hit[b] = 1'b0;
            zone_req_hit[b] = 1'b0;
            for (int z = 0; z < NZ; z++) begin
                if (pin_r.bay_zone_map[b*NZ+z]) begin
                    bay_ext_ok[b] = bay_ext_ok[b] & zone_ext_ok[z];
                    zone_hit[b] = zone_hit[b] | zone_trip_nxt[z];
                    zone_req_hit[b] = zone_req_hit[b] | pin_r.zone_trip_req[z];
                end
            end
            bay_ok[b] = bay_rel_r ? gate_open(crit_eff, bay_volt_ok[b], bay_ext_ok[b]) : 1'b1;
            redir_act[b] = ctrl_r[CTRL_BFP_REL] & pin_r.trip_redirect_req[b]
                & (~ctrl_r[CTRL_REDIR_LC] | cur_hi[b]);
            redir_fire[b] = redir_act[b] & (pin_r.bay_trip_req[b] | zone_req_hit[b]);
            bf_cnt_nxt[b] = bf_cnt_r[b];
            if (!pin_r.failure_start[b] || !ctrl_r[CTRL_BFP_REL]) begin
                bf_cnt_nxt[b] = '0;
            end else if (tick && bf_cnt_r[b] != {MS_W{1'b1}}) begin
                bf_cnt_nxt[b] = bf_cnt_r[b] + MS_W'(1);
            end
            retrip_nxt[b] = pin_r.failure_start[b] && ctrl_r[CTRL_BFP_REL] && bf_cnt_r[b] >= d1_eff
                && bay_ok[b] && cur_ok[b] && !redir_act[b];
            bf_intertrip[b] = pin_r.failure_start[b] && ctrl_r[CTRL_BFP_REL] && bf_cnt_r[b] >= d2_eff
                && cur_ok[b];
            remote_nxt[b] = (bf_intertrip[b] | redir_fire[b]) & bay_ok[b];
            bay_trip_nxt[b] = ((pin_r.bay_trip_req[b] & bay_ok[b]) | zone_hit[b]) & cur_ok[b] & ~redir_act[b];
        end
        for (int z = 0; z < NZ; z++) begin
            local_int_nxt[z] = 1'b0;
            for (int b = 0; b < NB; b++) begin
                if (pin_r.bay_zone_map[b*NZ+z] && (bf_intertrip[b] || redir_fire[b])) begin
                    local_int_nxt[z] = zone_rel[z];
                end
            end
        end
    end

    // Register bus next state.
    always_comb begin
        ctrl_nxt = ctrl_r;
        crit_nxt = crit_r;
        bay_rel_nxt = bay_rel_r;
        pickup_nxt = pickup_r;
        delay1_nxt = delay1_r;
        delay2_nxt = delay2_r;
        aw_full_nxt = aw_full_r && !(bvalid_r && s_axi_bready);
        aw_addr_nxt = aw_addr_r;
        w_full_nxt = w_full_r && !(bvalid_r && s_axi_bready);
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_axi_awvalid && !aw_full_r) begin
            aw_full_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full_r) begin
            w_full_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        // Both halves are held until the response is accepted, which keeps one write in flight.
        if (aw_full_r && w_full_r && !bvalid_r) begin
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            case (aw_addr_r)
                CTRL_OFS: if (w_strb_r[0]) ctrl_nxt = w_data_r[CTRL_W-1:0];
                CRIT_OFS: begin
                    if (w_strb_r[0]) begin
                        // illegal criterion falls back to none
                        crit_nxt = crit_legal(crit_e'(w_data_r[2:0]), ctrl_r) ? crit_e'(w_data_r[2:0]) : CRIT_NONE;
                        bay_rel_nxt = w_data_r[CRIT_BAY_BIT] && crit_nxt != CRIT_NONE;
                    end
                end
                PICKUP_OFS: begin
                    if (w_strb_r[0] && w_data_r[CUR_W-1:0] >= PICKUP_MIN && w_data_r[CUR_W-1:0] <= PICKUP_MAX) begin
                        pickup_nxt = w_data_r[CUR_W-1:0];
                    end
                end
                DELAY1_OFS: if (&w_strb_r[1:0]) delay1_nxt = w_data_r[MS_W-1:0];
                DELAY2_OFS: if (&w_strb_r[1:0]) delay2_nxt = w_data_r[MS_W-1:0];
                STATUS_OFS, INPUTS_OFS: bresp_nxt = RESP_OKAY;
                default: bresp_nxt = RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            case (s_axi_araddr)
                CTRL_OFS: rdata_nxt = 32'(ctrl_r);
                CRIT_OFS: rdata_nxt = 32'({bay_rel_r, crit_r});
                PICKUP_OFS: rdata_nxt = 32'(pickup_r);
                DELAY1_OFS: rdata_nxt = 32'(delay1_r);
                DELAY2_OFS: rdata_nxt = 32'(delay2_r);
                STATUS_OFS: rdata_nxt = 32'({failure_remote_transfer_trip, failure_local_intertrip,
                    failure_retrip, bay_trip, zone_trip});
                INPUTS_OFS: rdata_nxt = 32'({crit_eff, redir_act, zone_rel, pin_r.zone_external_release});
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
            crit_r <= CRIT_NONE;
            bay_rel_r <= 1'b0;
            pickup_r <= PICKUP_RST;
            delay1_r <= DELAY1_RST;
            delay2_r <= DELAY2_RST;
            aw_full_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_full_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            tick_r <= 32'h0;
            for (int b = 0; b < NB; b++) begin
                bf_cnt_r[b] <= '0;
            end
            zone_trip <= '0;
            bay_trip <= '0;
            failure_retrip <= '0;
            failure_local_intertrip <= '0;
            failure_remote_transfer_trip <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            crit_r <= crit_nxt;
            bay_rel_r <= bay_rel_nxt;
            pickup_r <= pickup_nxt;
            delay1_r <= delay1_nxt;
            delay2_r <= delay2_nxt;
            aw_full_r <= aw_full_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_full_r <= w_full_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            tick_r <= tick_nxt;
            for (int b = 0; b < NB; b++) begin
                bf_cnt_r[b] <= bf_cnt_nxt[b];
            end
            zone_trip <= zone_trip_nxt;
            bay_trip <= bay_trip_nxt;
            failure_retrip <= retrip_nxt;
            failure_local_intertrip <= local_int_nxt;
            failure_remote_transfer_trip <= remote_nxt;
        end
    end

    assign s_axi_awready = ~aw_full_r;
    assign s_axi_wready = ~w_full_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
endmodule : trip_release_redirection
